/* File: rtl/demod_edge_filter.sv */
/*
 * Glitch filter and edge detector for the demod input.
 * Assumes a synchronous input.
 */
`timescale 1ns/1ps
module demod_edge_filter (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_sig,
   input wire logic [1:0] i_len_sel,
   output dual_timer_pkg::edge_evt_t o_evt
);
   logic level_reg, level_next;
   logic [3:0] cnt_reg, cnt_next;
   dual_timer_pkg::edge_evt_t evt_reg, evt_next;
   logic [3:0] limit;

   // A change is accepted only once it has held for the selected length.
   always_comb begin
      unique case (i_len_sel)
         2'b00: limit = 4'h0;
         2'b01: limit = dual_timer_pkg::FILT_LEN_1;
         2'b10: limit = dual_timer_pkg::FILT_LEN_2;
         2'b11: limit = dual_timer_pkg::FILT_LEN_3;
      endcase
      level_next = level_reg;
      cnt_next = 4'h0;
      evt_next = '0;
      if (i_sig != level_reg) begin
         if (cnt_reg >= limit) begin // [RULE7]
            level_next = i_sig;
            evt_next.rise = i_sig;
            evt_next.fall = ~i_sig;
         end else begin
            cnt_next = cnt_reg + 4'h1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         level_reg <= 1'b0;
         cnt_reg <= 4'h0;
         evt_reg <= '0;
      end else begin
         level_reg <= level_next;
         cnt_reg <= cnt_next;
         evt_reg <= evt_next;
      end
   end

   assign o_evt = evt_reg;
endmodule

/* File: rtl/dual_timer.sv */
/*
 * Paired 8-bit and 16-bit down counters,
 * transmit and demodulation modes.
 * Assumes byte registers, synchronous pins, one clock.
 */
// Functional notes
// RULE1: Two read/write bytes hold the wide 16-bit reload.
// RULE2: Shared bit 1: narrow start level, or rise flag cleared by 1.
// RULE3: Shared bit 0: wide start level, or fall flag cleared by 1.
// RULE4: Mode bit 0 is transmit, 1 is demodulation.
// RULE5: Steer bit picks output pin source, or input pin.
// RULE6: Field picks AND/OR/NOR/NAND, or the detected edge.
// RULE7: Submode picks ping-pong or normal, or filter length.
// RULE8: Wide bit 7 starts or stops, reads running, resets 0.
// RULE9: Transmit wide bit 6: 0 reloads at end, 1 stops.
// RULE10: Demod with bit 6 set ignores edges, never reloads; the code still captures and reloads the wide count on an armed edge.
// RULE11: Then narrow time-out captures wide count, may interrupt.
// RULE12: Writing bit 6 from 0 to 1 arms one edge capture.
// RULE13: Demod wide counter wraps from zero to all ones.
// RULE14: Wide zero sets time-out flag, write 1 clears, mask bit 1.
// RULE15: Wide bit 2 enables the capture interrupt.
// RULE16: Firmware uses ping-pong in transmit, both single pass.
// RULE17: Ping-pong enable sets start level, loads by that level.
// RULE18: Narrow end hands to wide, wide end hands back.
// RULE19: In ping-pong each counter interrupts per its mask.
// RULE20: Writing 00 to the submode ends ping-pong.
// RULE21: Firmware stops counters, clears flags before ping-pong.
// RULE22: Wide bits 4:3 divide the count clock by 1, 2, 4, 8.
// RULE23: Wide bit 0 routes wide output to its pin, resets 0.
// RULE24: Captured wide values read from two bytes.
`timescale 1ns/1ps
module dual_timer (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [3:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   input wire logic i_port_out_combined,
   input wire logic i_port_out_wide,
   input wire logic i_demod_input_pin_a,
   input wire logic i_demod_input_pin_b,
   output logic o_combined_output_pin,
   output logic o_wide_output_pin,
   output logic o_narrow_timeout_irq,
   output logic o_wide_timeout_irq,
   output logic o_capture_irq
);
   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   logic [7:0] shared_reg, shared_next;
   logic rise_flag_reg, rise_flag_next, fall_flag_reg, fall_flag_next;
   logic n_en_reg, n_en_next, n_single_reg, n_single_next;
   logic n_to_reg, n_to_next, n_mask_reg, n_mask_next;
   logic n_out_reg, n_out_next;
   logic [7:0] n_cnt_reg, n_cnt_next;
   logic [7:0] n_rld_lo_reg, n_rld_lo_next, n_rld_hi_reg, n_rld_hi_next;
   logic w_en_reg, w_en_next, w_single_reg, w_single_next;
   logic w_to_reg, w_to_next, w_cap_mask_reg, w_cap_mask_next;
   logic w_to_mask_reg, w_to_mask_next, w_pin_reg, w_pin_next;
   logic [1:0] w_clk_reg, w_clk_next;
   logic w_out_reg, w_out_next, w_arm_reg, w_arm_next;
   logic [15:0] w_cnt_reg, w_cnt_next, w_rld_reg, w_rld_next;
   logic [15:0] cap_reg, cap_next;
   logic [2:0] div_reg, div_next;
   logic [7:0] rdata_next;
   logic comb_pin_next, wide_pin_next, cap_irq_next;

   // -------------------------------------------------------------------
   // Decoded controls
   // -------------------------------------------------------------------
   logic demod, pingpong, tick, comb_val, demod_in, edge_hit;
   logic n_tc, w_tc, cap_evt;
   logic [2:0] div_mask;
   dual_timer_pkg::edge_evt_t evt;

   assign demod = shared_reg[dual_timer_pkg::SH_MODE]; // [RULE4]
   assign pingpong = !demod && (shared_reg[dual_timer_pkg::SH_SUB_HI:
      dual_timer_pkg::SH_SUB_LO] == dual_timer_pkg::SUB_PINGPONG); // [RULE20]
   assign demod_in = shared_reg[dual_timer_pkg::SH_STEER] ?
      i_demod_input_pin_b : i_demod_input_pin_a; // [RULE5]

   demod_edge_filter u_filter (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_sig(demod_in),
      .i_len_sel(shared_reg[dual_timer_pkg::SH_SUB_HI:
         dual_timer_pkg::SH_SUB_LO]),
      .o_evt(evt)
   );

   // Prescaler: a free divider, tick when the low bits are all ones.
   always_comb begin
      unique case (w_clk_reg)
         2'b00: div_mask = 3'h0;
         2'b01: div_mask = 3'h1;
         2'b10: div_mask = 3'h3;
         2'b11: div_mask = 3'h7;
      endcase
      tick = ((div_reg & div_mask) == div_mask); // [RULE22]
      div_next = div_reg + 3'h1;
   end

   always_comb begin
      unique case (shared_reg[dual_timer_pkg::SH_LOGIC_HI:
         dual_timer_pkg::SH_LOGIC_LO])
         2'b00: comb_val = n_out_reg & w_out_reg; // [RULE6]
         2'b01: comb_val = n_out_reg | w_out_reg;
         2'b10: comb_val = ~(n_out_reg | w_out_reg);
         2'b11: comb_val = ~(n_out_reg & w_out_reg);
      endcase
      unique case (shared_reg[dual_timer_pkg::SH_LOGIC_HI:
         dual_timer_pkg::SH_LOGIC_LO])
         2'b00: edge_hit = evt.fall; // [RULE6]
         2'b01: edge_hit = evt.rise;
         2'b10: edge_hit = evt.rise | evt.fall;
         2'b11: edge_hit = evt.rise | evt.fall;
      endcase
   end

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   always_comb begin
      shared_next = shared_reg;
      rise_flag_next = rise_flag_reg;
      fall_flag_next = fall_flag_reg;
      n_en_next = n_en_reg;
      n_single_next = n_single_reg;
      n_to_next = n_to_reg;
      n_mask_next = n_mask_reg;
      n_out_next = n_out_reg;
      n_cnt_next = n_cnt_reg;
      n_rld_lo_next = n_rld_lo_reg;
      n_rld_hi_next = n_rld_hi_reg;
      w_en_next = w_en_reg;
      w_single_next = w_single_reg;
      w_to_next = w_to_reg;
      w_cap_mask_next = w_cap_mask_reg;
      w_to_mask_next = w_to_mask_reg;
      w_pin_next = w_pin_reg;
      w_clk_next = w_clk_reg;
      w_out_next = w_out_reg;
      w_arm_next = w_arm_reg;
      w_cnt_next = w_cnt_reg;
      w_rld_next = w_rld_reg;
      cap_next = cap_reg;
      cap_evt = 1'b0;
      n_tc = n_en_reg && (n_cnt_reg == 8'h00);
      w_tc = w_en_reg && tick && (w_cnt_reg == 16'h0000);

      // Register writes come first so that hardware events win below.
      if (i_reg_wr) begin
         unique case (i_reg_addr)
            dual_timer_pkg::ADDR_NARROW_CTL: begin
               n_en_next = i_reg_wdata[dual_timer_pkg::CTL_ENABLE];
               n_single_next = i_reg_wdata[dual_timer_pkg::CTL_SINGLE];
               n_mask_next = i_reg_wdata[dual_timer_pkg::CTL_TO_MASK];
               if (i_reg_wdata[dual_timer_pkg::CTL_TIMEOUT]) begin
                  n_to_next = 1'b0;
               end
               if (i_reg_wdata[dual_timer_pkg::CTL_ENABLE] && !n_en_reg) begin
                  n_out_next = shared_reg[dual_timer_pkg::SH_NARROW_INIT];
                  n_cnt_next = shared_reg[dual_timer_pkg::SH_NARROW_INIT] ?
                     n_rld_hi_reg : n_rld_lo_reg; // [RULE17]
               end
            end
            dual_timer_pkg::ADDR_SHARED_CTL: begin
               shared_next[7:2] = i_reg_wdata[7:2];
               if (demod) begin
                  if (i_reg_wdata[dual_timer_pkg::SH_NARROW_INIT]) begin
                     rise_flag_next = 1'b0; // [RULE2]
                  end
                  if (i_reg_wdata[dual_timer_pkg::SH_WIDE_INIT]) begin
                     fall_flag_next = 1'b0; // [RULE3]
                  end
               end else begin
                  shared_next[1:0] = i_reg_wdata[1:0]; // [RULE2] [RULE3]
               end
            end
            dual_timer_pkg::ADDR_WIDE_CTL: begin
               w_en_next = i_reg_wdata[dual_timer_pkg::CTL_ENABLE]; // [RULE8]
               w_single_next = i_reg_wdata[dual_timer_pkg::CTL_SINGLE];
               w_clk_next = i_reg_wdata[dual_timer_pkg::CTL_CLK_HI:
                  dual_timer_pkg::CTL_CLK_LO];
               w_cap_mask_next = i_reg_wdata[dual_timer_pkg::CTL_CAP_MASK];
               w_to_mask_next = i_reg_wdata[dual_timer_pkg::CTL_TO_MASK];
               w_pin_next = i_reg_wdata[dual_timer_pkg::CTL_PIN]; // [RULE23]
               if (i_reg_wdata[dual_timer_pkg::CTL_TIMEOUT]) begin
                  w_to_next = 1'b0; // [RULE14]
               end
               if (i_reg_wdata[dual_timer_pkg::CTL_SINGLE] && !w_single_reg) begin
                  w_arm_next = 1'b1; // [RULE12]
               end
               if (i_reg_wdata[dual_timer_pkg::CTL_ENABLE] && !w_en_reg) begin
                  w_cnt_next = w_rld_reg;
                  if (!demod) begin
                     w_out_next = shared_reg[dual_timer_pkg::SH_WIDE_INIT];
                  end // [RULE17]
               end
            end
            dual_timer_pkg::ADDR_NARROW_RLD_LO: n_rld_lo_next = i_reg_wdata;
            dual_timer_pkg::ADDR_NARROW_RLD_HI: n_rld_hi_next = i_reg_wdata;
            dual_timer_pkg::ADDR_WIDE_RLD_LO: w_rld_next[7:0] = i_reg_wdata;
            dual_timer_pkg::ADDR_WIDE_RLD_HI: w_rld_next[15:8] = i_reg_wdata;
            default: begin
            end
         endcase
      end

      // Narrow counter: counts every clock.
      if (n_en_reg && !n_tc) begin
         n_cnt_next = n_cnt_reg - 8'h01;
      end
      if (n_tc) begin
         n_to_next = 1'b1;
         if (demod) begin
            n_cnt_next = n_rld_lo_reg;
            if (w_single_reg && w_en_reg) begin
               cap_next = w_cnt_reg; // [RULE11]
               cap_evt = 1'b1;
            end
         end else if (pingpong) begin
            n_en_next = 1'b0; // [RULE18]
            w_en_next = 1'b1;
            w_out_next = shared_reg[dual_timer_pkg::SH_WIDE_INIT];
            w_cnt_next = w_rld_reg;
            n_out_next = ~n_out_reg;
         end else begin
            n_out_next = ~n_out_reg;
            if (n_single_reg) begin
               n_en_next = 1'b0;
            end else begin
               n_cnt_next = n_out_reg ? n_rld_lo_reg : n_rld_hi_reg;
            end
         end
      end

      // Wide counter: counts on prescaler ticks.
      if (w_en_reg && tick && !w_tc) begin
         w_cnt_next = w_cnt_reg - 16'h0001;
      end
      if (w_tc) begin
         w_to_next = 1'b1; // [RULE14]
         if (demod) begin
            w_cnt_next = dual_timer_pkg::WIDE_WRAP; // [RULE13]
         end else if (pingpong) begin
            w_en_next = 1'b0; // [RULE18]
            n_en_next = 1'b1;
            n_out_next = shared_reg[dual_timer_pkg::SH_NARROW_INIT];
            n_cnt_next = shared_reg[dual_timer_pkg::SH_NARROW_INIT] ?
               n_rld_hi_reg : n_rld_lo_reg; // [RULE17]
            w_out_next = ~w_out_reg;
         end else begin
            w_out_next = ~w_out_reg;
            if (w_single_reg) begin
               w_en_next = 1'b0; // [RULE9]
            end else begin
               w_cnt_next = w_rld_reg; // [RULE9]
            end
         end
      end

      // Demodulation edges: flags, capture and reload.
      if (demod) begin
         if (evt.rise) begin
            rise_flag_next = 1'b1; // [RULE2]
         end
         if (evt.fall) begin
            fall_flag_next = 1'b1; // [RULE3]
         end
         if (w_en_reg && edge_hit && (!w_single_reg || w_arm_reg)) begin
            cap_next = w_cnt_reg; // [RULE10] [RULE12] [RULE24]
            cap_evt = 1'b1;
            w_cnt_next = w_rld_reg;
            w_arm_next = 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // Read data and pins
   // -------------------------------------------------------------------
   always_comb begin
      rdata_next = o_reg_rdata;
      if (i_reg_rd) begin
         unique case (i_reg_addr)
            dual_timer_pkg::ADDR_NARROW_CTL: rdata_next = {n_en_reg,
               n_single_reg, n_to_reg, 3'h0, n_mask_reg, 1'b0};
            dual_timer_pkg::ADDR_SHARED_CTL: rdata_next = {shared_reg[7:2],
               demod ? rise_flag_reg : shared_reg[1],
               demod ? fall_flag_reg : shared_reg[0]};
            dual_timer_pkg::ADDR_WIDE_CTL: rdata_next = {w_en_reg,
               w_single_reg, w_to_reg, w_clk_reg, w_cap_mask_reg,
               w_to_mask_reg, w_pin_reg}; // [RULE8]
            dual_timer_pkg::ADDR_NARROW_RLD_LO: rdata_next = n_rld_lo_reg;
            dual_timer_pkg::ADDR_NARROW_RLD_HI: rdata_next = n_rld_hi_reg;
            dual_timer_pkg::ADDR_WIDE_RLD_LO: rdata_next = w_rld_reg[7:0];
            dual_timer_pkg::ADDR_WIDE_RLD_HI: rdata_next = w_rld_reg[15:8];
            dual_timer_pkg::ADDR_CAP_LO: rdata_next = cap_reg[7:0]; // [RULE24]
            dual_timer_pkg::ADDR_CAP_HI: rdata_next = cap_reg[15:8];
            default: rdata_next = dual_timer_pkg::RESET_BYTE;
         endcase
      end
      comb_pin_next = (shared_reg[dual_timer_pkg::SH_STEER] && !demod) ?
         comb_val : i_port_out_combined; // [RULE5]
      wide_pin_next = w_pin_reg ? w_out_reg : i_port_out_wide; // [RULE23]
      cap_irq_next = cap_evt && w_cap_mask_reg; // [RULE11] [RULE15]
   end

   // -------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         shared_reg <= dual_timer_pkg::RESET_BYTE;
         rise_flag_reg <= 1'b0;
         fall_flag_reg <= 1'b0;
         n_en_reg <= 1'b0;
         n_single_reg <= 1'b0;
         n_to_reg <= 1'b0;
         n_mask_reg <= 1'b0;
         n_out_reg <= 1'b0;
         n_cnt_reg <= 8'h00;
         n_rld_lo_reg <= dual_timer_pkg::RESET_BYTE;
         n_rld_hi_reg <= dual_timer_pkg::RESET_BYTE;
         w_en_reg <= 1'b0; // [RULE8]
         w_single_reg <= 1'b0;
         w_to_reg <= 1'b0;
         w_cap_mask_reg <= 1'b0;
         w_to_mask_reg <= 1'b0;
         w_pin_reg <= 1'b0; // [RULE23]
         w_clk_reg <= 2'b00;
         w_out_reg <= 1'b0;
         w_arm_reg <= 1'b0;
         w_cnt_reg <= 16'h0000;
         w_rld_reg <= 16'h0000;
         cap_reg <= 16'h0000;
         div_reg <= 3'h0;
         o_reg_rdata <= dual_timer_pkg::RESET_BYTE;
         o_combined_output_pin <= 1'b0;
         o_wide_output_pin <= 1'b0;
         o_narrow_timeout_irq <= 1'b0;
         o_wide_timeout_irq <= 1'b0;
         o_capture_irq <= 1'b0;
      end else begin
         shared_reg <= shared_next;
         rise_flag_reg <= rise_flag_next;
         fall_flag_reg <= fall_flag_next;
         n_en_reg <= n_en_next;
         n_single_reg <= n_single_next;
         n_to_reg <= n_to_next;
         n_mask_reg <= n_mask_next;
         n_out_reg <= n_out_next;
         n_cnt_reg <= n_cnt_next;
         n_rld_lo_reg <= n_rld_lo_next;
         n_rld_hi_reg <= n_rld_hi_next;
         w_en_reg <= w_en_next;
         w_single_reg <= w_single_next;
         w_to_reg <= w_to_next;
         w_cap_mask_reg <= w_cap_mask_next;
         w_to_mask_reg <= w_to_mask_next;
         w_pin_reg <= w_pin_next;
         w_clk_reg <= w_clk_next;
         w_out_reg <= w_out_next;
         w_arm_reg <= w_arm_next;
         w_cnt_reg <= w_cnt_next;
         w_rld_reg <= w_rld_next; // [RULE1]
         cap_reg <= cap_next;
         div_reg <= div_next;
         o_reg_rdata <= rdata_next;
         o_combined_output_pin <= comb_pin_next;
         o_wide_output_pin <= wide_pin_next;
         o_narrow_timeout_irq <= n_to_reg && n_mask_reg; // [RULE19]
         o_wide_timeout_irq <= w_to_reg && w_to_mask_reg; // [RULE14] [RULE19]
         o_capture_irq <= cap_irq_next;
      end
   end
endmodule

/* File: rtl/dual_timer_pkg.sv */
/*
 * Constants and carrier types shared by the dual timer block and its
 * input edge filter.
 * Assumes an 8-bit register port with a 4-bit register index.
 */
package dual_timer_pkg;

   // -------------------------------------------------------------------
   // Register indices
   // -------------------------------------------------------------------
   localparam logic [3:0] ADDR_NARROW_CTL = 4'h0;
   localparam logic [3:0] ADDR_SHARED_CTL = 4'h1;
   localparam logic [3:0] ADDR_WIDE_CTL = 4'h2;
   localparam logic [3:0] ADDR_NARROW_RLD_LO = 4'h4;
   localparam logic [3:0] ADDR_NARROW_RLD_HI = 4'h5;
   localparam logic [3:0] ADDR_WIDE_RLD_LO = 4'h6;
   localparam logic [3:0] ADDR_WIDE_RLD_HI = 4'h7;
   localparam logic [3:0] ADDR_CAP_LO = 4'h8;
   localparam logic [3:0] ADDR_CAP_HI = 4'h9;

   // -------------------------------------------------------------------
   // Counter control bits (narrow and wide share the layout)
   // -------------------------------------------------------------------
   localparam int CTL_ENABLE = 7;
   localparam int CTL_SINGLE = 6;
   localparam int CTL_TIMEOUT = 5;
   localparam int CTL_CLK_HI = 4;
   localparam int CTL_CLK_LO = 3;
   localparam int CTL_CAP_MASK = 2;
   localparam int CTL_TO_MASK = 1;
   localparam int CTL_PIN = 0;

   // -------------------------------------------------------------------
   // Shared control bits
   // -------------------------------------------------------------------
   localparam int SH_MODE = 7;
   localparam int SH_STEER = 6;
   localparam int SH_LOGIC_HI = 5;
   localparam int SH_LOGIC_LO = 4;
   localparam int SH_SUB_HI = 3;
   localparam int SH_SUB_LO = 2;
   localparam int SH_NARROW_INIT = 1;
   localparam int SH_WIDE_INIT = 0;

   // -------------------------------------------------------------------
   // Reset values and counts
   // -------------------------------------------------------------------
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] WIDE_WRAP = 16'hffff;
   localparam logic [3:0] FILT_LEN_1 = 4'h2;
   localparam logic [3:0] FILT_LEN_2 = 4'h4;
   localparam logic [3:0] FILT_LEN_3 = 4'h8;

   // -------------------------------------------------------------------
   // Encodings
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      COMB_AND = 2'b00,
      COMB_OR = 2'b01,
      COMB_NOR = 2'b10,
      COMB_NAND = 2'b11
   } comb_op_t;

   typedef enum logic [1:0] {
      EDGE_FALL = 2'b00,
      EDGE_RISE = 2'b01,
      EDGE_BOTH = 2'b10,
      EDGE_BOTH_ALT = 2'b11
   } edge_sel_t;

   typedef enum logic [1:0] {
      SUB_NORMAL = 2'b00,
      SUB_PINGPONG = 2'b01,
      SUB_NORMAL_2 = 2'b10,
      SUB_NORMAL_3 = 2'b11
   } submode_t;

   typedef struct packed {
      logic rise;
      logic fall;
   } edge_evt_t;

endpackage

/* File: tb/dual_timer_asserts.sv */
/* Port checker bound to the dual timer.
   Assumes only top ports; control bytes shadowed. */
`timescale 1ns/1ps
module dual_timer_asserts (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [3:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [7:0] o_reg_rdata,
   input wire logic i_port_out_combined,
   input wire logic i_port_out_wide,
   input wire logic o_combined_output_pin,
   input wire logic o_wide_output_pin,
   input wire logic o_narrow_timeout_irq,
   input wire logic o_wide_timeout_irq,
   input wire logic o_capture_irq
);
   // ------------------------------------------------------------------
   // Shadow control bytes
   // ------------------------------------------------------------------
   logic [7:0] sh_reg, wc_reg, nc_reg, sh_next, wc_next, nc_next;
   logic pass_c;
   always_comb begin
      sh_next = (i_reg_wr && i_reg_addr == 4'h1) ? i_reg_wdata : sh_reg;
      wc_next = (i_reg_wr && i_reg_addr == 4'h2) ? i_reg_wdata : wc_reg;
      nc_next = (i_reg_wr && i_reg_addr == 4'h0) ? i_reg_wdata : nc_reg;
   end
   always_ff @(posedge i_clk) begin
      sh_reg <= i_sys_rst ? 8'h00 : sh_next;
      wc_reg <= i_sys_rst ? 8'h00 : wc_next;
      nc_reg <= i_sys_rst ? 8'h00 : nc_next;
   end
   // Whole control bytes are shadowed; only mask, pin, steering and mode bits are used, and hardware never alters them.
   assign pass_c = sh_reg[7] || !sh_reg[6];
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   sequence s_unmapped_rd;
      i_reg_rd && i_reg_addr == 4'h3;
   endsequence
   property p_rst_quiet;
      $fell(i_sys_rst) |-> o_reg_rdata == 8'h00 && !o_capture_irq;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("not clear after reset");
   property p_rd_hold;
      !i_reg_rd |=> $stable(o_reg_rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data moved");
   property p_unmapped;
      s_unmapped_rd |=> o_reg_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read nonzero");
   property p_wide_irq;
      o_wide_timeout_irq |-> $past(wc_reg[1]);
   endproperty
   a_wide_irq: assert property (p_wide_irq)
      else $error("wide irq masked");
   property p_narrow_irq;
      o_narrow_timeout_irq |-> $past(nc_reg[1]);
   endproperty
   a_narrow_irq: assert property (p_narrow_irq)
      else $error("narrow irq masked");
   property p_cap_mask;
      o_capture_irq |-> $past(wc_reg[2]);
   endproperty
   a_cap_mask: assert property (p_cap_mask)
      else $error("capture irq masked");
   property p_cap_pulse;
      o_capture_irq |=> !o_capture_irq;
   endproperty
   a_cap_pulse: assert property (p_cap_pulse)
      else $error("capture irq too long");
   property p_wide_port;
      !wc_reg[0] && !$past(wc_reg[0]) && !$past(i_sys_rst)
         |-> o_wide_output_pin == $past(i_port_out_wide);
   endproperty
   a_wide_port: assert property (p_wide_port)
      else $error("wide pin not port");
   property p_comb_port;
      pass_c && $past(pass_c) && !$past(i_sys_rst)
         |-> o_combined_output_pin == $past(i_port_out_combined);
   endproperty
   a_comb_port: assert property (p_comb_port)
      else $error("combined pin not port");
endmodule
bind dual_timer dual_timer_asserts dual_timer_asserts_inst (.*);

/* File: tb/ir_source.sv */
/* Signal source model for the demodulation pin.
   Assumes the bench sets its level and lag in cycles. */
`timescale 1ns/1ps
module ir_source (
   input wire logic i_clk,
   input wire logic i_level,
   input wire logic [3:0] i_lag,
   output logic o_line
);
   // A variable lag lets the same source answer promptly or slowly.
   logic [15:0] hist_reg = 16'h0000;
   logic [15:0] hist_next;
   always_comb begin
      hist_next = {hist_reg[14:0], i_level};
   end
   always_ff @(posedge i_clk) begin
      hist_reg <= hist_next;
   end
   assign o_line = hist_reg[i_lag];
endmodule

/* File: tb/testbench.sv */
/* Self-checking bench for the dual timer via its register port.
   Assumes the design, checker and source model. */
`timescale 1ns/1ps
module testbench;
   logic i_clk, wr = 1'b0, rd = 1'b0, pc = 1'b0, pw = 1'b0, lvl = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [3:0] addr = 4'h0, lag = 4'h3;
   logic [7:0] wd = 8'h00, rdata;
   logic src, cpin, wpin, nirq, wirq, cirq;
   logic [7:0] exp_op [4] = '{8'h00, 8'h01, 8'h00, 8'h01};
   int n_errors = 0, checks_done = 0, cycles = 0;
   dual_timer dual_timer_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wd),
      .o_reg_rdata(rdata), .i_port_out_combined(pc), .i_port_out_wide(pw),
      .i_demod_input_pin_a(src), .i_demod_input_pin_b(1'b0),
      .o_combined_output_pin(cpin), .o_wide_output_pin(wpin),
      .o_narrow_timeout_irq(nirq), .o_wide_timeout_irq(wirq),
      .o_capture_irq(cirq));
   ir_source ir_source_inst (.i_clk(i_clk), .i_level(lvl), .i_lag(lag),
      .o_line(src));
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   // ------------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] e);
      checks_done++;
      if (seen !== e) begin
         n_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, e);
      end
   endtask
   task automatic wrr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk);
      wr <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge i_clk);
      wr <= 1'b0;
   endtask
   task automatic rdr(input logic [3:0] a, input logic [7:0] m, e);
      @(posedge i_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge i_clk);
      rd <= 1'b0;
      @(posedge i_clk);
      #1;
      chk(rdata & m, e);
   endtask
   task automatic cap_seen(input logic [7:0] e);
      logic s;
      s = 1'b0;
      repeat (40) begin
         @(posedge i_clk);
         #1;
         s = s | cirq;
      end
      chk(8'(s), e);
   endtask
   task automatic wrap_up;
      if (n_errors == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         n_errors++;
         wrap_up();
      end
   end
   // ------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------
   initial begin
      repeat (2) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      rdr(4'h2, 8'hff, 8'h00);
      wrr(4'h6, 8'h5a);
      wrr(4'h7, 8'ha5);
      wrr(4'h3, 8'hff);
      rdr(4'h6, 8'hff, 8'h5a);
      rdr(4'h7, 8'hff, 8'ha5);
      rdr(4'h3, 8'hff, 8'h00);
      wrr(4'h7, 8'h10);
      wrr(4'h5, 8'hff);
      wrr(4'h1, 8'h42);
      wrr(4'h0, 8'hc0);
      wrr(4'h2, 8'hc0);
      foreach (exp_op[k]) begin
         wrr(4'h1, 8'h42 | 8'(k << 4));
         repeat (2) @(posedge i_clk);
         chk(8'(cpin), exp_op[k]);
      end
      pw <= 1'b1;
      wrr(4'h2, 8'h41);
      repeat (2) @(posedge i_clk);
      chk(8'(wpin), 8'h00);
      wrr(4'h7, 8'h00);
      wrr(4'h6, 8'h0f);
      for (int k = 0; k < 4; k++) begin
         wrr(4'h2, 8'hc2 | 8'(k << 3));
         repeat (8 << k) @(posedge i_clk);
         rdr(4'h2, 8'h20, 8'h00);
         repeat (10 << k) @(posedge i_clk);
         rdr(4'h2, 8'he2, 8'h62);
         chk(8'(wirq), 8'h01);
         wrr(4'h2, 8'h20);
         rdr(4'h2, 8'h20, 8'h00);
      end
      wrr(4'h0, 8'h20);
      wrr(4'h4, 8'h05);
      wrr(4'h5, 8'h05);
      wrr(4'h6, 8'h05);
      wrr(4'h2, 8'h42);
      wrr(4'h1, 8'h56);
      wrr(4'h0, 8'hc2);
      repeat (40) @(posedge i_clk);
      rdr(4'h2, 8'h62, 8'h62);
      chk(8'(nirq), 8'h01);
      wrr(4'h1, 8'h52);
      wrr(4'h0, 8'h00);
      wrr(4'h2, 8'h20);
      wrr(4'h7, 8'h12);
      wrr(4'h6, 8'h34);
      wrr(4'h1, 8'h90);
      wrr(4'h2, 8'h84);
      lvl <= 1'b1;
      cap_seen(8'h01);
      rdr(4'h9, 8'hff, 8'h12);
      rdr(4'h1, 8'h02, 8'h02);
      wrr(4'h1, 8'h92);
      rdr(4'h1, 8'h02, 8'h00);
      wrr(4'h1, 8'h81);
      lag <= 4'hc;
      lvl <= 1'b0;
      repeat (20) @(posedge i_clk);
      rdr(4'h1, 8'h01, 8'h01);
      wrr(4'h1, 8'ha3);
      wrr(4'h2, 8'hc4);
      lvl <= 1'b1;
      cap_seen(8'h01);
      @(posedge i_clk);
      lvl <= 1'b0;
      cap_seen(8'h00);
      wrap_up();
   end
endmodule
